// file: bsm_pkg.sv
package bsm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int WORD_W = 64;
  localparam int CHK_W = 8;
  localparam int BLOCK_WORDS = 64;
  localparam int BLOCK_LG = 6;
  localparam int BUF_WORDS = 16;
  localparam int NUM_PORTS = 5;
  localparam int IO_CHANS = 4;
  localparam int ADDR_W = 32;
  localparam logic [2:0] PORT_IO = 3'h2;
  localparam logic [2:0] PORT_MF_A = 3'h3;
  localparam logic [2:0] PORT_MF_B = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int REFRESH_NS = 15600;
  localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
  localparam int REFRESH_HOLD_NS = 100;
  localparam int REFRESH_HOLD_CYC = (REFRESH_HOLD_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [WORD_W-1:0] bsm_word_t;
  typedef logic [CHK_W-1:0] bsm_chk_t;

  // Data word with its checkbyte
  typedef struct packed {
    bsm_word_t data;
    bsm_chk_t chk;
  } bsm_cw_t;

  // Block request of one port
  typedef struct packed {
    logic req;
    logic wr;
    logic [1:0] chan;
    logic [ADDR_W-1:0] addr;
  } bsm_req_t;

  // Record sent to the error logger
  typedef struct packed {
    logic single;
    logic dbl;
    logic wr;
    logic [2:0] port;
    logic [BLOCK_LG-1:0] word;
    bsm_chk_t syn;
  } bsm_log_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_REFR  = 5'h02,
    ST_WRITE = 5'h04,
    ST_READ  = 5'h08,
    ST_DONE  = 5'h10
  } bsm_state_t;

endpackage

// file: bsm_secded.sv
`timescale 1ns/1ps
module bsm_secded (
  input bsm_pkg::bsm_word_t data_in, // Word to check or encode
  input bsm_pkg::bsm_chk_t chk_in, // Checkbyte stored with the word
  output bsm_pkg::bsm_chk_t chk_gen, // Checkbyte computed from data_in
  output bsm_pkg::bsm_word_t data_fix, // Corrected word
  output logic err_single, // One bit altered, corrected
  output logic err_double, // Two bits altered, not corrected
  output bsm_pkg::bsm_chk_t syndrome // Syndrome for the logger
);
  import bsm_pkg::*;

  logic [71:1] cw;
  int j;

  // ----------------------------------------------------------------
  // Extended Hamming code over 64 data bits
  // ----------------------------------------------------------------
  // Data fills code positions that are not powers of two; seven
  // position checks plus one overall parity bit.
  always_comb begin
    cw = '0;
    j = 0;
    chk_gen = '0;
    data_fix = data_in;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = data_in[j];
        j = j + 1;
      end
    end
    for (int i = 0; i < 7; i++) begin
      for (int p = 1; p < 72; p++) begin
        if (p[i]) begin
          chk_gen[i] = chk_gen[i] ^ cw[p];
        end
      end
    end
    chk_gen[7] = (^data_in) ^ (^chk_gen[6:0]);
    syndrome = {(^data_in) ^ (^chk_in), chk_gen[6:0] ^ chk_in[6:0]};
    // Odd overall parity means a single flip; even with a nonzero
    // position means two flips. Three or more are not reliable.
    err_single = syndrome[7];
    err_double = !syndrome[7] && (syndrome[6:0] != 7'h00);
    j = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (err_single && (syndrome[6:0] == p[6:0])) begin
          data_fix[j] = !data_in[j];
        end
        j = j + 1;
      end
    end
  end

endmodule // bsm_secded

// file: bsm_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Every transfer moves one whole 64-word block; no single words.
// - Each stored word gets a freshly computed 8-bit Hamming checkbyte.
// - Read words with a clean syndrome go out unchanged.
// - A single flipped bit is corrected, forwarded and logged.
// - Double errors on ports 2-4 flag mainframe status or set I/O busy and done; logged.
// - Incoming write words are checked and corrected before storage.
// - Five ports; port 0 refreshes, port 1 serves the maintenance computer.
// - Port 2 carries four I/O channels; ports 3 and 4 mainframe channels.
// - Simultaneous requests go to the lowest port number.
// - Each block passes through two 16-word staging buffers.
// - The two buffers take alternate words of the block.
// - Storage is split into identical parallel groups, word-steered.
// - The small configuration has no port 4.
// - Busy and done flags report I/O channel progress and completion.
module bsm_ctrl #(
  parameter int MEM_BLKS = 16, // Blocks of storage
  parameter int GROUPS = 2, // Parallel memory groups, power of two
  parameter bit HAS_PORT4 = 1'b1 // Clear for the small configuration
) (
  input logic sys_clk, // 40 MHz clock
  input logic rst_n, // Asynchronous reset, active low
  input bsm_pkg::bsm_req_t [4:1] req, // Block requests of ports 1..4
  input logic wr_valid, // Write word present from granted port
  input bsm_pkg::bsm_cw_t wr_word, // Write word with channel checkbyte
  input logic [3:0] io_done_clr, // I/O processor clears done
  input logic [1:0] mf_err_clr, // Mainframe clears its error flag
  output logic [4:0] grant, // One-hot granted port
  output logic rd_valid, // Read word strobe
  output bsm_pkg::bsm_word_t rd_data, // Read word, corrected
  output logic blk_done, // Block finished, one cycle
  output logic log_valid, // Error record strobe
  output bsm_pkg::bsm_log_t log_info, // Error record
  output logic [3:0] io_busy, // I/O channel busy flags
  output logic [3:0] io_done, // I/O channel done flags
  output logic [1:0] mf_err // Mainframe status error flags
);
  import bsm_pkg::*;

  localparam int GL = $clog2(GROUPS);
  localparam int BW = $clog2(MEM_BLKS);
  localparam int ROWS = MEM_BLKS * BLOCK_WORDS / GROUPS;
  localparam int RW = BW + BLOCK_LG - GL;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bsm_state_t state_q, state_d;
  logic [2:0] port_q, port_d;
  logic [1:0] chan_q, chan_d;
  logic [BW-1:0] blk_q, blk_d;
  logic [6:0] cnt_q, cnt_d;
  logic [9:0] rtmr_q, rtmr_d;
  logic rpend_q, rpend_d;
  logic stg_vld_q, stg_vld_d;
  logic stg_wr_q, stg_wr_d;
  logic [5:0] stg_idx_q, stg_idx_d;
  logic bdbl_q, bdbl_d;
  logic [4:0] grant_q, grant_d;
  logic rd_valid_q, rd_valid_d;
  bsm_word_t rd_data_q, rd_data_d;
  logic blk_done_q, blk_done_d;
  logic log_valid_q, log_valid_d;
  bsm_log_t log_q, log_d;
  logic [3:0] io_busy_q, io_busy_d;
  logic [3:0] io_done_q, io_done_d;
  logic [1:0] mf_err_q, mf_err_d;

  // Staging buffers and datapath
  bsm_cw_t xbuf [2][BUF_WORDS];
  logic buf_we;
  logic [5:0] buf_idx;
  bsm_cw_t buf_din;
  bsm_cw_t stg_word;
  bsm_cw_t grp_rd [GROUPS];
  logic [RW-1:0] rd_row;
  logic [GL-1:0] rd_grp;
  logic [RW-1:0] wr_row;
  logic [GL-1:0] wr_grp;
  logic mem_we;
  logic [4:0] rvec;
  logic [2:0] win;
  logic take_wr;
  logic [5:0] idx;

  // Channel-side checker and store-side checker
  bsm_word_t a_fix, b_fix;
  bsm_chk_t a_syn, b_syn, b_gen;
  logic a_sgl, a_dbl, b_sgl, b_dbl;
  logic ev_sgl, ev_dbl, ev_wr;
  bsm_chk_t ev_syn;
  logic [5:0] ev_idx;

  // ----------------------------------------------------------------
  // Check units
  // ----------------------------------------------------------------
  // Unit A guards data as it arrives from the channel
  bsm_secded u_chk_in (
    .data_in(wr_word.data),
    .chk_in(wr_word.chk),
    .chk_gen(),
    .data_fix(a_fix),
    .err_single(a_sgl),
    .err_double(a_dbl),
    .syndrome(a_syn)
  );

  // Unit B encodes staged write words and decodes staged read words
  bsm_secded u_chk_mem (
    .data_in(stg_word.data),
    .chk_in(stg_word.chk),
    .chk_gen(b_gen),
    .data_fix(b_fix),
    .err_single(b_sgl),
    .err_double(b_dbl),
    .syndrome(b_syn)
  );

  // ----------------------------------------------------------------
  // Staging buffers
  // ----------------------------------------------------------------
  // Even words sit in buffer 0, odd words in buffer 1, 16 slots each
  assign stg_word = xbuf[stg_idx_q[0]][stg_idx_q[4:1]];

  always_ff @(posedge sys_clk) begin
    if (buf_we) begin
      xbuf[buf_idx[0]][buf_idx[4:1]] <= buf_din;
    end
  end

  // ----------------------------------------------------------------
  // Memory groups
  // ----------------------------------------------------------------
  // Low word bits pick the group, so neighbouring words use separate
  // groups; each group is one parallel path of identical shape.
  assign rd_grp = idx[GL-1:0];
  assign rd_row = {blk_q, idx[5:GL]};
  assign wr_grp = stg_idx_q[GL-1:0];
  assign wr_row = {blk_q, stg_idx_q[5:GL]};
  assign mem_we = stg_vld_q && stg_wr_q;

  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    bsm_cw_t mem [ROWS];
    always_ff @(posedge sys_clk) begin
      if (mem_we && (wr_grp == GL'(g))) begin
        mem[wr_row] <= '{data: stg_word.data, chk: b_gen};
      end
    end
    assign grp_rd[g] = mem[rd_row];
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Port 0 is the internal refresh timer; port 4 drops out when absent
  always_comb begin
    rvec = {req[4].req && HAS_PORT4, req[3].req, req[2].req, req[1].req,
            rpend_q};
    win = 3'h0;
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      if (rvec[p]) begin
        win = p[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Error event selection
  // ----------------------------------------------------------------
  // Write errors show on arrival, read errors once staged; the two
  // never overlap since a block is either read or written.
  assign idx = cnt_q[5:0];
  assign take_wr = (state_q == ST_WRITE) && wr_valid && !cnt_q[6];

  always_comb begin
    ev_wr = take_wr;
    ev_sgl = take_wr ? a_sgl : (stg_vld_q && !stg_wr_q && b_sgl);
    ev_dbl = take_wr ? a_dbl : (stg_vld_q && !stg_wr_q && b_dbl);
    ev_syn = take_wr ? a_syn : b_syn;
    ev_idx = take_wr ? idx : stg_idx_q;
  end

  // ----------------------------------------------------------------
  // Control next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    port_d = port_q;
    chan_d = chan_q;
    blk_d = blk_q;
    cnt_d = cnt_q;
    rtmr_d = rtmr_q;
    rpend_d = rpend_q;
    stg_vld_d = 1'b0;
    stg_wr_d = stg_wr_q;
    stg_idx_d = stg_idx_q;
    bdbl_d = bdbl_q;
    grant_d = grant_q;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    blk_done_d = 1'b0;
    log_valid_d = 1'b0;
    log_d = log_q;
    io_busy_d = io_busy_q;
    io_done_d = io_done_q & ~io_done_clr;
    mf_err_d = mf_err_q & ~mf_err_clr;
    buf_we = 1'b0;
    buf_idx = idx;
    buf_din = grp_rd[rd_grp];

    // Refresh timer raises port 0 at a fixed interval
    if (rtmr_q == 10'h000) begin
      rtmr_d = 10'(REFRESH_CYC - 1);
    end else begin
      rtmr_d = rtmr_q - 10'h001;
    end

    case (state_q)
      ST_IDLE: begin
        if (rvec != 5'h00) begin
          port_d = win;
          grant_d = 5'(5'h01 << win);
          cnt_d = 7'h00;
          bdbl_d = 1'b0;
          if (win == 3'h0) begin
            state_d = ST_REFR;
          end else begin
            // Only the block number is kept; word bits are dropped
            blk_d = req[win].addr[BLOCK_LG +: BW];
            chan_d = req[win].chan;
            state_d = req[win].wr ? ST_WRITE : ST_READ;
            if (win == PORT_IO) begin
              io_busy_d[req[win].chan] = 1'b1;
              io_done_d[req[win].chan] = 1'b0;
            end
          end
        end
      end
      ST_REFR: begin
        // Storage is held idle while the refresh slot runs
        cnt_d = cnt_q + 7'h01;
        if (cnt_q == 7'(REFRESH_HOLD_CYC - 1)) begin
          rpend_d = 1'b0;
          grant_d = 5'h00;
          state_d = ST_IDLE;
        end
      end
      ST_WRITE: begin
        // Corrected channel word is staged, stored on the next cycle
        if (take_wr) begin
          buf_we = 1'b1;
          buf_din = '{data: a_fix, chk: wr_word.chk};
          stg_vld_d = 1'b1;
          stg_wr_d = 1'b1;
          stg_idx_d = idx;
          cnt_d = cnt_q + 7'h01;
          if (idx == 6'(BLOCK_WORDS - 1)) begin
            state_d = ST_DONE;
          end
        end
      end
      ST_READ: begin
        // One word a cycle from its group into the staging buffer
        buf_we = 1'b1;
        stg_vld_d = 1'b1;
        stg_wr_d = 1'b0;
        stg_idx_d = idx;
        cnt_d = cnt_q + 7'h01;
        if (idx == 6'(BLOCK_WORDS - 1)) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        blk_done_d = 1'b1;
        grant_d = 5'h00;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        grant_d = 5'h00;
      end
    endcase

    // Staged read word leaves corrected, or untouched when clean
    if (stg_vld_q && !stg_wr_q) begin
      rd_valid_d = 1'b1;
      rd_data_d = b_fix;
    end

    // Every detected error goes to the logger
    if (ev_sgl || ev_dbl) begin
      log_valid_d = 1'b1;
      log_d = '{single: ev_sgl, dbl: ev_dbl, wr: ev_wr, port: port_q,
                word: ev_idx, syn: ev_syn};
    end

    // Double errors on ports 2 to 4 raise the requester's own error signalling
    if (ev_dbl) begin
      bdbl_d = 1'b1;
      if (port_q == PORT_IO) begin
        io_busy_d[chan_q] = 1'b1;
        io_done_d[chan_q] = 1'b1;
      end else if (port_q == PORT_MF_A) begin
        mf_err_d[0] = 1'b1;
      end else if (port_q == PORT_MF_B) begin
        mf_err_d[1] = 1'b1;
      end
    end

    // End of an I/O block: done set, busy kept only after a double
    if ((state_q == ST_DONE) && (port_q == PORT_IO)) begin
      io_done_d[chan_q] = 1'b1;
      io_busy_d[chan_q] = bdbl_q || ev_dbl;
    end

    // A timer expiry in the clearing cycle is kept
    if (rtmr_q == 10'h000) begin
      rpend_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      port_q <= 3'h0;
      chan_q <= 2'h0;
      blk_q <= '0;
      cnt_q <= 7'h00;
      rtmr_q <= 10'h000;
      rpend_q <= 1'b0;
      stg_vld_q <= 1'b0;
      stg_wr_q <= 1'b0;
      stg_idx_q <= 6'h00;
      bdbl_q <= 1'b0;
      grant_q <= 5'h00;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
      blk_done_q <= 1'b0;
      log_valid_q <= 1'b0;
      log_q <= '0;
      io_busy_q <= 4'h0;
      io_done_q <= 4'h0;
      mf_err_q <= 2'h0;
    end else begin
      state_q <= state_d;
      port_q <= port_d;
      chan_q <= chan_d;
      blk_q <= blk_d;
      cnt_q <= cnt_d;
      rtmr_q <= rtmr_d;
      rpend_q <= rpend_d;
      stg_vld_q <= stg_vld_d;
      stg_wr_q <= stg_wr_d;
      stg_idx_q <= stg_idx_d;
      bdbl_q <= bdbl_d;
      grant_q <= grant_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
      blk_done_q <= blk_done_d;
      log_valid_q <= log_valid_d;
      log_q <= log_d;
      io_busy_q <= io_busy_d;
      io_done_q <= io_done_d;
      mf_err_q <= mf_err_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign grant = grant_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign blk_done = blk_done_q;
  assign log_valid = log_valid_q;
  assign log_info = log_q;
  assign io_busy = io_busy_q;
  assign io_done = io_done_q;
  assign mf_err = mf_err_q;

endmodule // bsm_ctrl

// file: bsm_ctrl_properties.sv
`timescale 1ns/1ps
module bsm_ctrl_props
  import bsm_pkg::*;
#(
  parameter bit HAS_PORT4 = 1'b1 // Clear for the small configuration
) (
  input logic sys_clk, // Clock
  input logic rst_n, // Asynchronous reset, active low
  input bsm_pkg::bsm_req_t [4:1] req, // Block requests of ports 1..4
  input logic wr_valid, // Write word strobe
  input logic [4:0] grant, // One-hot granted port
  input logic rd_valid, // Read word strobe
  input logic blk_done, // Block end pulse
  input logic log_valid, // Error record strobe
  input bsm_pkg::bsm_log_t log_info, // Error record
  input logic [3:0] io_busy, // I/O busy flags
  input logic [3:0] io_done, // I/O done flags
  input logic [1:0] mf_err // Mainframe error flags
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [6:0] rd_cnt_q, rd_cnt_d;
  logic [4:1] rq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Request levels only; the rest of each request is not needed here
  assign rq = {req[4].req, req[3].req, req[2].req, req[1].req};

  // Read words since the last block end; cleared at blk_done
  always_comb begin
    rd_cnt_d = rd_cnt_q + {6'h00, rd_valid};
    if (blk_done) begin
      rd_cnt_d = 7'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_cnt_q <= 7'h00;
    end else begin
      rd_cnt_q <= rd_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  grant_onehot_a: assert property ($onehot0(grant))
    else $error("grant is not one-hot");
  refr_hold_a: assert property ($rose(grant[0]) |-> grant[0] [*4] ##1 !grant[0])
    else $error("refresh grant length wrong");
  low_first_a: assert property (($past(grant) == 5'h00 && grant[4:1] != 4'h0) |->
    ((grant[4:1] & $past(rq)) != 4'h0 && ((grant[4:1] - 4'h1) & $past(rq)) == 4'h0))
    else $error("grant not to lowest requesting port");
  no_port4_a: assert property (grant[4] |-> HAS_PORT4)
    else $error("port 4 granted in small configuration");
  blk_pulse_a: assert property (blk_done |-> grant == 5'h00 ##1 !blk_done)
    else $error("block end pulse wrong");
  blk_words_a: assert property (blk_done && (rd_valid || rd_cnt_q != 7'h00) |->
    rd_cnt_q == 7'h3F && rd_valid)
    else $error("read block not 64 words");
  log_kind_a: assert property (log_valid |->
    log_info.single != log_info.dbl && log_info.single == log_info.syn[7])
    else $error("error record kind wrong");
  rd_log_a: assert property (log_valid && !log_info.wr |-> rd_valid)
    else $error("read error record without read word");
  wr_log_a: assert property (log_valid && log_info.wr |->
    $past(wr_valid) || $past(wr_valid, 2))
    else $error("write error record without write word");
  mf_flag_a: assert property (log_valid && log_info.dbl && log_info.port == PORT_MF_A
    |-> ##[0:1] mf_err[0])
    else $error("mainframe error flag not set");
  io_flag_a: assert property (log_valid && log_info.dbl && log_info.port == PORT_IO
    |-> ##[0:1] (io_busy & io_done) != 4'h0)
    else $error("busy and done not both set");
  io_busy_a: assert property ($rose(grant[2]) |-> ##[0:1] io_busy != 4'h0)
    else $error("busy not set at grant");
endmodule // bsm_ctrl_props

bind bsm_ctrl bsm_ctrl_props #(.HAS_PORT4(HAS_PORT4)) u_props (.sys_clk(sys_clk),
  .rst_n(rst_n), .req(req), .wr_valid(wr_valid), .grant(grant), .rd_valid(rd_valid),
  .blk_done(blk_done), .log_valid(log_valid), .log_info(log_info), .io_busy(io_busy),
  .io_done(io_done), .mf_err(mf_err));

// file: bsm_chan_model.sv
`timescale 1ns/1ps
module bsm_chan_model
  import bsm_pkg::*;
(
  input logic sys_clk, // Clock
  input logic rst_n, // Reset, active low
  input logic [4:0] grant, // One-hot grant from the memory
  input logic [4:1] wr_ports, // Ports whose block is a write
  input bsm_pkg::bsm_word_t base, // Data seed of the block
  input logic slow, // Pause one cycle after each word
  input logic [5:0] err_word, // Index of the corrupted word
  input bsm_pkg::bsm_word_t err_mask, // Data bits flipped on that word
  output logic wr_valid, // Write word strobe
  output bsm_pkg::bsm_cw_t wr_word // Write word with checkbyte
);
  localparam bsm_word_t K = 64'h9E37_79B9_7F4A_7C15;
  int cnt;
  logic gap;

  // Channel checkbyte: extended Hamming, parity over all 72 bits
  function automatic bsm_cw_t enc(bsm_word_t d);
    int j;
    int p;
    bsm_chk_t c;
    j = 0;
    c = 8'h00;
    for (p = 3; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[j]) c[6:0] ^= 7'(p);
        j++;
      end
    end
    c[7] = ^{d, c[6:0]};
    return {d, c};
  endfunction

  // Sends words 0..63 in order while a writing port holds grant
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt = 0;
      gap = 1'b0;
      wr_valid <= 1'b0;
      wr_word <= '0;
    end else if (|(grant[4:1] & wr_ports) && cnt < 64 && !gap) begin
      wr_valid <= 1'b1;
      wr_word <= enc(base ^ (64'(cnt) * K)) ^
        {(cnt == int'(err_word)) ? err_mask : 64'h0, 8'h00};
      cnt++;
      gap = slow;
    end else begin
      // Released lines must not keep showing the last word
      wr_valid <= 1'b0;
      wr_word <= ~wr_word;
      gap = 1'b0;
      if (grant[4:1] == 4'h0) cnt = 0;
    end
  end
endmodule // bsm_chan_model

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import bsm_pkg::*;
  localparam bsm_word_t K = 64'h9E37_79B9_7F4A_7C15;
  logic sys_clk, rst_n, wr_valid, rd_valid, blk_done, log_valid, slow;
  bsm_req_t [4:1] req;
  bsm_cw_t wr_word;
  bsm_word_t rd_data, base, err_mask;
  bsm_log_t log_info;
  logic [4:0] grant;
  logic [4:1] wr_ports;
  logic [3:0] io_done_clr, io_busy, io_done;
  logic [1:0] mf_err_clr, mf_err;
  logic [5:0] err_word;
  logic [63:0] seed;
  int miscompares, num_checks;
  bsm_word_t mem [int];

  bsm_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .wr_valid(wr_valid),
    .wr_word(wr_word), .io_done_clr(io_done_clr), .mf_err_clr(mf_err_clr), .grant(grant),
    .rd_valid(rd_valid), .rd_data(rd_data), .blk_done(blk_done), .log_valid(log_valid),
    .log_info(log_info), .io_busy(io_busy), .io_done(io_done), .mf_err(mf_err));

  bsm_chan_model u_chan (.sys_clk(sys_clk), .rst_n(rst_n), .grant(grant),
    .wr_ports(wr_ports), .base(base), .slow(slow), .err_word(err_word),
    .err_mask(err_mask), .wr_valid(wr_valid), .wr_word(wr_word));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic bsm_word_t xs();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed;
  endfunction

  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic guard(int t, int lim);
    if (t >= lim) begin
      miscompares++;
      $display("[ERR] wait expected %0d seen %0d", lim, t);
      close_out();
    end
  endtask

  // Expected storage: single errors are repaired, doubles kept as sent;
  // every stored word gets a fresh checkbyte, so a double reads back clean
  function automatic void fill(int blk, bsm_word_t b, int errs, int errw, bsm_word_t m);
    for (int k = 0; k < 64; k++) mem[blk * 64 + k] = b ^ (64'(k) * K);
    if (errs == 2) mem[blk * 64 + errw] ^= m;
  endfunction

  // One block on port p; errs is 0, 1 or 2 bits wrong at word errw
  task automatic run_blk(int p, bit wr, int ch, int blk, int errs, int errw);
    int t, k, n, b1, b2;
    bsm_word_t b, m;
    b = xs();
    b1 = int'(xs() % 64);
    b2 = (b1 + 1 + int'(xs() % 63)) % 64;
    m = (errs > 0 ? 64'h1 << b1 : 64'h0) | (errs > 1 ? 64'h1 << b2 : 64'h0);
    if (wr) fill(blk, b, errs, errw, m);
    @(posedge sys_clk);
    base <= b;
    err_mask <= m;
    err_word <= 6'(errw);
    slow <= b[0];
    wr_ports <= 4'(wr) << (p - 1);
    req[p] <= {1'b1, wr, 2'(ch), ADDR_W'(blk * 64)};
    for (t = 0; t < 1000 && grant[p] !== 1'b1; t++) @(negedge sys_clk);
    guard(t, 1000);
    @(posedge sys_clk);
    req[p] <= '0;
    k = 0;
    n = 0;
    for (t = 0; t < 300 && blk_done !== 1'b1; t++) begin
      @(negedge sys_clk);
      if (rd_valid === 1'b1) begin
        chk("rd_data", rd_data, mem[blk * 64 + k]);
        k++;
      end
      if (log_valid === 1'b1) begin
        n++;
        chk("log", log_info[19:8], {errs == 1, errs == 2, wr, 3'(p), 6'(errw)});
      end
    end
    guard(t, 300);
    chk("words", k, wr ? 0 : 64);
    chk("logs", n, errs > 0);
    if (p == 2) chk("io_flags", {io_busy[ch], io_done[ch]}, {errs == 2, 1'b1});
    if (p > 2) chk("mf_err", mf_err[p - 3], errs == 2);
    @(posedge sys_clk);
    io_done_clr <= 4'hF;
    mf_err_clr <= 2'h3;
    @(posedge sys_clk);
    io_done_clr <= 4'h0;
    mf_err_clr <= 2'h0;
    @(negedge sys_clk);
    chk("cleared", {io_done, mf_err}, 64'h0);
    $display("Test port %0d %s block %0d done", p, wr ? "write" : "read", blk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int t, n, i;
    bsm_req_t [4:1] r;
    bsm_word_t b;
    seed = 64'h0000_0000_0000_004A;
    miscompares = 0;
    num_checks = 0;
    rst_n = 1'b0;
    req = '0;
    io_done_clr = 4'h0;
    mf_err_clr = 2'h0;
    wr_ports = 4'h0;
    base = 64'h0;
    err_mask = 64'h0;
    err_word = 6'h00;
    slow = 1'b0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("reset", {grant, rd_valid, blk_done, log_valid, io_busy, io_done, mf_err}, 64'h0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    // Refresh takes the first slot and holds it a fixed time
    for (t = 0; t < 10 && grant !== 5'h01; t++) @(negedge sys_clk);
    guard(t, 10);
    for (n = 0; n < 20 && grant[0] === 1'b1; n++) @(negedge sys_clk);
    chk("refresh_len", n, REFRESH_HOLD_CYC);
    $display("Test reset and refresh done");
    run_blk(3, 1, 0, 1, 1, 5);
    run_blk(3, 0, 0, 1, 0, 0);
    run_blk(4, 1, 0, 2, 2, 9);
    run_blk(3, 0, 0, 2, 0, 0);
    run_blk(1, 1, 0, 8, 1, 63);
    run_blk(1, 0, 0, 8, 0, 0);
    // Every I/O channel, with clean, single and double faults
    for (i = 0; i < 4; i++) begin
      run_blk(2, 1, i, 3 + i, i % 3, i * 20);
      run_blk(2, 0, i, 3 + i, 0, 0);
    end
    // Four ports ask in the same cycle; lowest number must win each time
    b = xs();
    for (i = 1; i < 5; i++) begin
      fill(8 + i, b, 0, 0, 64'h0);
      r[i] = {1'b1, 1'b1, 2'h1, ADDR_W'((8 + i) * 64)};
    end
    @(posedge sys_clk);
    base <= b;
    err_mask <= 64'h0;
    wr_ports <= 4'hF;
    req <= r;
    for (i = 1; i < 5; i++) begin
      for (t = 0; t < 1000 && grant[4:1] === 4'h0; t++) @(negedge sys_clk);
      guard(t, 1000);
      chk("grant", grant, 5'h01 << i);
      @(posedge sys_clk);
      req[i] <= '0;
      for (t = 0; t < 300 && blk_done !== 1'b1; t++) @(negedge sys_clk);
      guard(t, 300);
    end
    $display("Test arbitration done");
    for (i = 1; i < 5; i++) run_blk(4, 0, 0, 8 + i, 0, 0);
    close_out();
  end
endmodule // tb_top
